// ---- crf_top.sv ----
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "crf_defs.svh"
// Function
// - Four 16-bit data registers serve transfer, arithmetic and logic.
// - First two data registers split into independent high and low bytes.
// - Third pairs with first, fourth with second, upper word on top.
// - Two 16-bit address registers for indirect, relative and data use.
// - Second address register joins the first as upper word of 32 bits.
// - 16-bit frame base gives the base for frame relative addressing.
// - 20-bit vector table base holds the interrupt table start.
// - 20-bit program counter holds the next instruction address.
// - Separate 16-bit user and interrupt stack pointers.
// - Stack-select flag picks the active stack pointer.
// - 16-bit static base gives the base for static relative addressing.
// - Flag register is 11 bits wide.
// - Carry flag keeps carry, borrow or shifted-out bit of the ALU.
// - Zero flag is one for a zero result, else zero.
// - Sign flag is one for a negative result, else zero.
// - Bank-select flag zero picks bank 0, one picks bank 1.
// - Overflow flag is one on overflow, else zero.
module crf_top
    import crf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire crf_wr_t exec_wr,
    input wire crf_alu_t alu_flags,
    input wire crf_pc_t pc_ctl,
    output crf_view_t regs_view
);

    // ==========================================================
    // State
    // Index 0-3 data, 4-5 address, 6 frame base
    logic [15:0] bank_regs [2][7];
    logic [15:0] next_bank_regs [2][7];
    logic [15:0] static_base;
    logic [15:0] next_static_base;
    logic [19:0] vector_table_base;
    logic [19:0] next_vector_table_base;
    logic [19:0] program_counter;
    logic [19:0] next_program_counter;
    logic [15:0] user_stack_pointer;
    logic [15:0] next_user_stack_pointer;
    logic [15:0] interrupt_stack_pointer;
    logic [15:0] next_interrupt_stack_pointer;
    logic [10:0] cpu_flags;
    logic [10:0] next_cpu_flags;
    crf_view_t next_regs_view;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // ==========================================================
    // Bus decode
    logic [3:0] apb_idx;
    logic apb_mapped;
    logic apb_wr;
    logic bank_sel;

    assign apb_idx = paddr[5:2];
    assign apb_mapped = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0)
        && (apb_idx <= 4'hc);
    // Write commits only on the completing access edge
    assign apb_wr = psel && penable && pready && pwrite && apb_mapped
        && (paddr != `CRF_OFF_PC);
    assign bank_sel = cpu_flags[`CRF_FLG_B];

    // ==========================================================
    // Next state of the register set
    always_comb begin
        logic [3:0] wsel;
        logic [2:0] widx;
        logic [31:0] res;
        wsel = exec_wr.sel;
        widx = wsel[2:0];
        res = alu_flags.result;
        next_bank_regs = bank_regs;
        next_static_base = static_base;
        next_vector_table_base = vector_table_base;
        next_program_counter = program_counter;
        next_user_stack_pointer = user_stack_pointer;
        next_interrupt_stack_pointer = interrupt_stack_pointer;
        next_cpu_flags = cpu_flags;

        // Software writes land in the bank the flag selects
        if (apb_wr) begin
            case (paddr)
                `CRF_OFF_DATA0, `CRF_OFF_DATA1, `CRF_OFF_DATA2,
                `CRF_OFF_DATA3, `CRF_OFF_ADDR0, `CRF_OFF_ADDR1,
                `CRF_OFF_FB: begin
                    next_bank_regs[bank_sel][apb_idx[2:0]] = pwdata[15:0];
                end
                `CRF_OFF_SB: begin
                    next_static_base = pwdata[15:0];
                end
                `CRF_OFF_VECTOR_TABLE_BASE: begin
                    next_vector_table_base = pwdata[19:0];
                end
                `CRF_OFF_USP: begin
                    next_user_stack_pointer = pwdata[15:0];
                end
                `CRF_OFF_ISP: begin
                    next_interrupt_stack_pointer = pwdata[15:0];
                end
                `CRF_OFF_FLG: begin
                    next_cpu_flags = pwdata[10:0];
                end
                default: begin
                end
            endcase
        end

        // The execution unit wins a same-cycle collision with the bus
        if (exec_wr.en) begin
            case (exec_wr.sel)
                CRF_SEL_D0, CRF_SEL_D1: begin
                    if (exec_wr.size == CRF_SZ_BYTE) begin
                        if (exec_wr.hi) begin
                            next_bank_regs[bank_sel][widx][15:8] = exec_wr.data[7:0];
                        end else begin
                            next_bank_regs[bank_sel][widx][7:0] = exec_wr.data[7:0];
                        end
                    end else begin
                        next_bank_regs[bank_sel][widx] = exec_wr.data[15:0];
                        if (exec_wr.size == CRF_SZ_LONG) begin
                            // Third or fourth register carries the upper word
                            next_bank_regs[bank_sel][widx + 3'h2] = exec_wr.data[31:16];
                        end
                    end
                end
                CRF_SEL_D2, CRF_SEL_D3, CRF_SEL_A1, CRF_SEL_FB: begin
                    if (exec_wr.size != CRF_SZ_BYTE) begin
                        next_bank_regs[bank_sel][widx] = exec_wr.data[15:0];
                    end
                end
                CRF_SEL_A0: begin
                    if (exec_wr.size != CRF_SZ_BYTE) begin
                        next_bank_regs[bank_sel][widx] = exec_wr.data[15:0];
                        if (exec_wr.size == CRF_SZ_LONG) begin
                            next_bank_regs[bank_sel][widx + 3'h1] = exec_wr.data[31:16];
                        end
                    end
                end
                CRF_SEL_SB: begin
                    next_static_base = exec_wr.data[15:0];
                end
                CRF_SEL_VECTOR_TABLE_BASE: begin
                    next_vector_table_base = exec_wr.data[19:0];
                end
                CRF_SEL_USP: begin
                    next_user_stack_pointer = exec_wr.data[15:0];
                end
                CRF_SEL_ISP: begin
                    next_interrupt_stack_pointer = exec_wr.data[15:0];
                end
                CRF_SEL_SP: begin
                    if (cpu_flags[`CRF_FLG_U]) begin
                        next_user_stack_pointer = exec_wr.data[15:0];
                    end else begin
                        next_interrupt_stack_pointer = exec_wr.data[15:0];
                    end
                end
                CRF_SEL_FLG: begin
                    next_cpu_flags = exec_wr.data[10:0];
                end
                default: begin
                end
            endcase
        end

        // ALU status beats any register write of the flags
        if (alu_flags.upd) begin
            next_cpu_flags[`CRF_FLG_C] = alu_flags.carry;
            next_cpu_flags[`CRF_FLG_O] = alu_flags.ovf;
            case (alu_flags.size)
                CRF_SZ_BYTE: begin
                    next_cpu_flags[`CRF_FLG_Z] = (res[7:0] == 8'h00);
                    next_cpu_flags[`CRF_FLG_S] = res[7];
                end
                CRF_SZ_LONG: begin
                    next_cpu_flags[`CRF_FLG_Z] = (res == 32'h0000_0000);
                    next_cpu_flags[`CRF_FLG_S] = res[31];
                end
                default: begin
                    next_cpu_flags[`CRF_FLG_Z] = (res[15:0] == 16'h0000);
                    next_cpu_flags[`CRF_FLG_S] = res[15];
                end
            endcase
        end

        // A jump target overrides the sequential advance
        if (pc_ctl.load) begin
            next_program_counter = pc_ctl.target;
        end else begin
            next_program_counter = program_counter + 20'(pc_ctl.step);
        end
    end

    // ==========================================================
    // Registered views, built from next state so that the view
    // always matches the register set it is flopped beside
    always_comb begin
        logic nb;
        nb = next_cpu_flags[`CRF_FLG_B];
        next_regs_view.data_reg_0 = next_bank_regs[nb][0];
        next_regs_view.data_reg_1 = next_bank_regs[nb][1];
        next_regs_view.data_reg_2 = next_bank_regs[nb][2];
        next_regs_view.data_reg_3 = next_bank_regs[nb][3];
        next_regs_view.data_pair_low = {next_bank_regs[nb][2], next_bank_regs[nb][0]};
        next_regs_view.data_pair_high = {next_bank_regs[nb][3], next_bank_regs[nb][1]};
        next_regs_view.addr_reg_0 = next_bank_regs[nb][4];
        next_regs_view.addr_reg_1 = next_bank_regs[nb][5];
        next_regs_view.addr_pair = {next_bank_regs[nb][5], next_bank_regs[nb][4]};
        next_regs_view.frame_base = next_bank_regs[nb][6];
        next_regs_view.static_base = next_static_base;
        next_regs_view.vector_table_base = next_vector_table_base;
        next_regs_view.program_counter = next_program_counter;
        next_regs_view.stack_pointer = next_cpu_flags[`CRF_FLG_U] ?
            next_user_stack_pointer : next_interrupt_stack_pointer;
        next_regs_view.cpu_flags = next_cpu_flags;
    end

    // ==========================================================
    // Bus slave: one wait-free access phase, data staged at setup
    always_comb begin
        next_pready = psel && !penable;
        next_pslverr = 1'b0;
        next_prdata = `CRF_RST_BUS;
        if (psel && !penable) begin
            next_pslverr = !apb_mapped || (pwrite && (paddr == `CRF_OFF_PC));
            if (!pwrite && apb_mapped) begin
                case (paddr)
                    `CRF_OFF_SB: next_prdata = {16'h0000, static_base};
                    `CRF_OFF_VECTOR_TABLE_BASE: next_prdata = {12'h000, vector_table_base};
                    `CRF_OFF_USP: next_prdata = {16'h0000, user_stack_pointer};
                    `CRF_OFF_ISP: next_prdata = {16'h0000, interrupt_stack_pointer};
                    `CRF_OFF_PC: next_prdata = {12'h000, program_counter};
                    `CRF_OFF_FLG: next_prdata = {21'h000000, cpu_flags};
                    default: begin
                        next_prdata = {16'h0000, bank_regs[bank_sel][apb_idx[2:0]]};
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int b = 0; b < 2; b++) begin
                for (int i = 0; i < 7; i++) begin
                    bank_regs[b][i] <= `CRF_RST_WORD;
                end
            end
            static_base <= `CRF_RST_WORD;
            vector_table_base <= `CRF_RST_ADDR20;
            program_counter <= `CRF_RST_ADDR20;
            user_stack_pointer <= `CRF_RST_WORD;
            interrupt_stack_pointer <= `CRF_RST_WORD;
            cpu_flags <= `CRF_RST_FLG;
            regs_view <= '0;
            prdata <= `CRF_RST_BUS;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            bank_regs <= next_bank_regs;
            static_base <= next_static_base;
            vector_table_base <= next_vector_table_base;
            program_counter <= next_program_counter;
            user_stack_pointer <= next_user_stack_pointer;
            interrupt_stack_pointer <= next_interrupt_stack_pointer;
            cpu_flags <= next_cpu_flags;
            regs_view <= next_regs_view;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_zero;
        alu_flags.upd && alu_flags.size == CRF_SZ_WORD
            && alu_flags.result[15:0] == 16'h0000
        |=> cpu_flags[`CRF_FLG_Z] && !cpu_flags[`CRF_FLG_S];
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag missed");

    property p_sign;
        alu_flags.upd && alu_flags.size == CRF_SZ_BYTE
        |=> cpu_flags[`CRF_FLG_S] == $past(alu_flags.result[7]);
    endproperty
    a_sign: assert property (p_sign) else $error("sign flag wrong");

    property p_carry_ovf;
        alu_flags.upd
        |=> cpu_flags[`CRF_FLG_C] == $past(alu_flags.carry)
            && cpu_flags[`CRF_FLG_O] == $past(alu_flags.ovf);
    endproperty
    a_carry_ovf: assert property (p_carry_ovf) else $error("carry or overflow wrong");

    property p_stack_sel;
        regs_view.stack_pointer == (cpu_flags[`CRF_FLG_U] ?
            user_stack_pointer : interrupt_stack_pointer);
    endproperty
    a_stack_sel: assert property (p_stack_sel) else $error("wrong stack pointer");

    property p_bank_write;
        exec_wr.en && exec_wr.sel == CRF_SEL_D1 && exec_wr.size == CRF_SZ_WORD
        |=> bank_regs[$past(bank_sel)][1] == $past(exec_wr.data[15:0])
            && bank_regs[!$past(bank_sel)][1] == $past(bank_regs[!bank_sel][1]);
    endproperty
    a_bank_write: assert property (p_bank_write) else $error("bank write leaked");

    property p_byte_hi;
        exec_wr.en && exec_wr.sel == CRF_SEL_D0 && exec_wr.size == CRF_SZ_BYTE
            && exec_wr.hi && !alu_flags.upd && !apb_wr
        |=> regs_view.data_reg_0 == {$past(exec_wr.data[7:0]),
            $past(bank_regs[bank_sel][0][7:0])};
    endproperty
    a_byte_hi: assert property (p_byte_hi) else $error("byte write disturbed low half");

    property p_pair;
        exec_wr.en && exec_wr.sel == CRF_SEL_D0 && exec_wr.size == CRF_SZ_LONG
            && !alu_flags.upd && !apb_wr
        |=> regs_view.data_pair_low == $past(exec_wr.data);
    endproperty
    a_pair: assert property (p_pair) else $error("long pair write wrong");

    property p_pc;
        pc_ctl.load |=> program_counter == $past(pc_ctl.target)
            && regs_view.program_counter == $past(pc_ctl.target);
    endproperty
    a_pc: assert property (p_pc) else $error("program counter load lost");

    // The view is built from next state, so it never lags the counter
    property p_pc_step;
        !pc_ctl.load
        |=> program_counter == $past(program_counter) + 20'($past(pc_ctl.step));
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("program counter step wrong");

    // A same-cycle bus write to the flags could flip the selector, so skip it
    property p_sp_write;
        exec_wr.en && exec_wr.sel == CRF_SEL_SP && !apb_wr
        |=> (cpu_flags[`CRF_FLG_U] ? user_stack_pointer : interrupt_stack_pointer)
            == $past(exec_wr.data[15:0]);
    endproperty
    a_sp_write: assert property (p_sp_write) else $error("active stack write missed");

    property p_apb_bank;
        apb_wr && paddr == `CRF_OFF_FB && !exec_wr.en
        |=> bank_regs[$past(bank_sel)][6] == $past(pwdata[15:0]);
    endproperty
    a_apb_bank: assert property (p_apb_bank) else $error("bus write missed its bank");

    property p_apb_done;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_apb_done: assert property (p_apb_done) else $error("bus access not one cycle");

endmodule : crf_top

// ---- crf_defs.svh ----
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH

// ==========================================================
// Register byte offsets on the bus
`define CRF_OFF_DATA0 12'h000
`define CRF_OFF_DATA1 12'h004
`define CRF_OFF_DATA2 12'h008
`define CRF_OFF_DATA3 12'h00c
`define CRF_OFF_ADDR0 12'h010
`define CRF_OFF_ADDR1 12'h014
`define CRF_OFF_FB 12'h018
`define CRF_OFF_SB 12'h01c
`define CRF_OFF_VECTOR_TABLE_BASE 12'h020
`define CRF_OFF_USP 12'h024
`define CRF_OFF_ISP 12'h028
`define CRF_OFF_PC 12'h02c
`define CRF_OFF_FLG 12'h030

// ==========================================================
// Flag register bit positions
`define CRF_FLG_C 0
`define CRF_FLG_D 1
`define CRF_FLG_Z 2
`define CRF_FLG_S 3
`define CRF_FLG_B 4
`define CRF_FLG_O 5
`define CRF_FLG_I 6
`define CRF_FLG_U 7

// ==========================================================
// Reset values
`define CRF_RST_WORD 16'h0000
`define CRF_RST_ADDR20 20'h00000
`define CRF_RST_FLG 11'h000
`define CRF_RST_BUS 32'h0000_0000

`endif

// ---- crf_pkg.sv ----
// ==========================================================
// Types shared by the register set
package crf_pkg;

    typedef enum logic [3:0] {
        CRF_SEL_D0, CRF_SEL_D1, CRF_SEL_D2, CRF_SEL_D3,
        CRF_SEL_A0, CRF_SEL_A1, CRF_SEL_FB, CRF_SEL_SB,
        CRF_SEL_VECTOR_TABLE_BASE, CRF_SEL_USP, CRF_SEL_ISP, CRF_SEL_SP,
        CRF_SEL_FLG
    } crf_sel_e_t;

    typedef enum logic [1:0] {
        CRF_SZ_BYTE, CRF_SZ_WORD, CRF_SZ_LONG
    } crf_size_e_t;

    typedef struct packed {
        logic en;
        crf_sel_e_t sel;
        crf_size_e_t size;
        logic hi;
        logic [31:0] data;
    } crf_wr_t;

    typedef struct packed {
        logic upd;
        crf_size_e_t size;
        logic carry;
        logic ovf;
        logic [31:0] result;
    } crf_alu_t;

    typedef struct packed {
        logic load;
        logic [19:0] target;
        logic [2:0] step;
    } crf_pc_t;

    typedef struct packed {
        logic [15:0] data_reg_0;
        logic [15:0] data_reg_1;
        logic [15:0] data_reg_2;
        logic [15:0] data_reg_3;
        logic [31:0] data_pair_low;
        logic [31:0] data_pair_high;
        logic [15:0] addr_reg_0;
        logic [15:0] addr_reg_1;
        logic [31:0] addr_pair;
        logic [15:0] frame_base;
        logic [15:0] static_base;
        logic [19:0] vector_table_base;
        logic [19:0] program_counter;
        logic [15:0] stack_pointer;
        logic [10:0] cpu_flags;
    } crf_view_t;

endpackage : crf_pkg

// ---- crf_exec_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Execution unit stand-in: one request per call, idle between
module crf_exec_model
    import crf_pkg::*;
(
    input wire logic pclk,
    output crf_wr_t exec_wr,
    output crf_alu_t alu_flags,
    output crf_pc_t pc_ctl
);
    initial begin
        exec_wr = '0;
        alu_flags = '0;
        pc_ctl = '0;
    end

    // Never targets the flag register, so the debug bit is left clear
    task automatic wr(input crf_sel_e_t s, input crf_size_e_t z, input logic h,
            input logic [31:0] d);
        @(posedge pclk);
        exec_wr <= '{en: 1'b1, sel: s, size: z, hi: h, data: d};
        @(posedge pclk);
        exec_wr <= '0;
        #1;
    endtask : wr

    task automatic alu(input crf_size_e_t z, input logic c, input logic o,
            input logic [31:0] r);
        @(posedge pclk);
        alu_flags <= '{upd: 1'b1, size: z, carry: c, ovf: o, result: r};
        @(posedge pclk);
        alu_flags <= '0;
        #1;
    endtask : alu

    // Step stays zero between calls so the counter holds still for checks
    task automatic pc_run(input logic ld, input logic [19:0] t, input logic [2:0] s,
            input int n);
        @(posedge pclk);
        pc_ctl <= '{load: ld, target: t, step: s};
        repeat (n) @(posedge pclk);
        pc_ctl <= '0;
        #1;
    endtask : pc_run
endmodule : crf_exec_model

// ---- tb.sv ----
`timescale 1ns/1ps
`include "crf_defs.svh"
module tb;
    import crf_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    crf_wr_t exec_wr;
    crf_alu_t alu_flags;
    crf_pc_t pc_ctl;
    crf_view_t view;
    int n_fail = 0;
    int tests_run = 0;

    always #10 pclk = ~pclk;

    crf_top u_crf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .exec_wr(exec_wr),
        .alu_flags(alu_flags), .pc_ctl(pc_ctl), .regs_view(view));

    crf_exec_model u_crf_exec_model (.pclk(pclk), .exec_wr(exec_wr),
        .alu_flags(alu_flags), .pc_ctl(pc_ctl));

    // ==========================================================
    // Reporting
    task automatic final_report();
        $display("Counts: %0d checks, %0d mismatches", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // ==========================================================
    // Bus access: request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [31:0] exp, input logic err);
        int i;
        logic [31:0] q;
        logic e;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            n_fail++;
            final_report();
        end
        check($sformatf("pslverr at %h", a), {31'h0, e}, {31'h0, err});
        if (!w)
            check($sformatf("read at %h", a), q, exp);
    endtask : apb

    task automatic alu_chk(input crf_size_e_t z, input logic c, input logic o,
            input logic [31:0] r, input logic [10:0] exp);
        u_crf_exec_model.alu(z, c, o, r);
        check("arith flags", 32'(view.cpu_flags & 11'h02d), 32'(exp));
    endtask : alu_chk

    initial begin
        // Watchdog against a hung handshake
        repeat (100000) @(posedge pclk);
        n_fail++;
        final_report();
    end

    initial begin
        int a;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (a = 0; a <= 'h30; a += 4)
            apb(1'b0, 12'(a), 0, 32'h0, 1'b0);
        $display("test reset values done");

        for (a = 0; a <= 'h28; a += 4)
            apb(1'b1, 12'(a), 32'hffff_ffff, 0, 1'b0);
        for (a = 0; a <= 'h28; a += 4)
            apb(1'b0, 12'(a), 0, (a == 'h20) ? 32'h000f_ffff : 32'h0000_ffff, 1'b0);
        apb(1'b1, `CRF_OFF_FLG, 32'hffff_fffd, 0, 1'b0);
        apb(1'b0, `CRF_OFF_FLG, 0, 32'h0000_07fd, 1'b0);
        apb(1'b1, `CRF_OFF_FLG, 32'h0, 0, 1'b0);
        $display("test widths done");

        apb(1'b1, `CRF_OFF_PC, 32'h0000_1234, 0, 1'b1);
        apb(1'b0, 12'h034, 0, 32'h0, 1'b1);
        apb(1'b0, 12'h002, 0, 32'h0, 1'b1);
        apb(1'b0, `CRF_OFF_PC, 0, 32'h0, 1'b0);
        $display("test refusals done");

        apb(1'b1, `CRF_OFF_FLG, 32'h0000_0010, 0, 1'b0);
        apb(1'b0, `CRF_OFF_DATA0, 0, 32'h0, 1'b0);
        apb(1'b1, `CRF_OFF_FB, 32'h0000_1234, 0, 1'b0);
        apb(1'b0, `CRF_OFF_FB, 0, 32'h0000_1234, 1'b0);
        apb(1'b1, `CRF_OFF_FLG, 32'h0, 0, 1'b0);
        apb(1'b0, `CRF_OFF_FB, 0, 32'h0000_ffff, 1'b0);
        apb(1'b0, `CRF_OFF_SB, 0, 32'h0000_ffff, 1'b0);
        $display("test banks done");

        apb(1'b1, `CRF_OFF_USP, 32'h0000_1111, 0, 1'b0);
        apb(1'b1, `CRF_OFF_ISP, 32'h0000_2222, 0, 1'b0);
        @(posedge pclk);
        check("stack isp", 32'(view.stack_pointer), 32'h2222);
        apb(1'b1, `CRF_OFF_FLG, 32'h0000_0080, 0, 1'b0);
        @(posedge pclk);
        check("stack usp", 32'(view.stack_pointer), 32'h1111);
        apb(1'b1, `CRF_OFF_FLG, 32'h0, 0, 1'b0);
        $display("test stacks done");

        u_crf_exec_model.wr(CRF_SEL_D0, CRF_SZ_LONG, 1'b0, 32'h89ab_cdef);
        check("pair low", view.data_pair_low, 32'h89ab_cdef);
        check("data2", 32'(view.data_reg_2), 32'h89ab);
        u_crf_exec_model.wr(CRF_SEL_D0, CRF_SZ_BYTE, 1'b1, 32'h0000_005a);
        check("data0 high", 32'(view.data_reg_0), 32'h5aef);
        u_crf_exec_model.wr(CRF_SEL_D1, CRF_SZ_BYTE, 1'b0, 32'h0000_0011);
        check("data1 low", 32'(view.data_reg_1), 32'hff11);
        u_crf_exec_model.wr(CRF_SEL_D1, CRF_SZ_LONG, 1'b0, 32'h0102_0304);
        check("pair high", view.data_pair_high, 32'h0102_0304);
        u_crf_exec_model.wr(CRF_SEL_A0, CRF_SZ_LONG, 1'b0, 32'hdead_beef);
        check("addr pair", view.addr_pair, 32'hdead_beef);
        check("addr1", 32'(view.addr_reg_1), 32'hdead);
        check("addr0", 32'(view.addr_reg_0), 32'hbeef);
        u_crf_exec_model.wr(CRF_SEL_D1, CRF_SZ_WORD, 1'b0, 32'h0000_7777);
        check("data1 word", 32'(view.data_reg_1), 32'h7777);
        check("data3 kept", 32'(view.data_reg_3), 32'h0102);
        u_crf_exec_model.wr(CRF_SEL_SP, CRF_SZ_WORD, 1'b0, 32'h0000_3333);
        check("active sp", 32'(view.stack_pointer), 32'h3333);
        apb(1'b0, `CRF_OFF_USP, 0, 32'h0000_1111, 1'b0);
        u_crf_exec_model.wr(CRF_SEL_FB, CRF_SZ_BYTE, 1'b0, 32'h0000_0055);
        check("frame base", 32'(view.frame_base), 32'h0000_ffff);
        check("static base", 32'(view.static_base), 32'h0000_ffff);
        $display("test exec writes done");

        alu_chk(CRF_SZ_WORD, 1'b0, 1'b0, 32'h0000_0000, 11'h004);
        alu_chk(CRF_SZ_WORD, 1'b1, 1'b0, 32'h0000_8000, 11'h009);
        alu_chk(CRF_SZ_BYTE, 1'b0, 1'b1, 32'h0000_0100, 11'h024);
        alu_chk(CRF_SZ_LONG, 1'b0, 1'b0, 32'h8000_0000, 11'h008);
        alu_chk(CRF_SZ_LONG, 1'b1, 1'b1, 32'h0000_0001, 11'h021);
        $display("test flags done");

        u_crf_exec_model.pc_run(1'b1, 20'habcde, 3'd0, 1);
        check("pc load", 32'(view.program_counter), 32'h000a_bcde);
        u_crf_exec_model.pc_run(1'b0, 20'h0, 3'd2, 5);
        apb(1'b0, `CRF_OFF_PC, 0, 32'h000a_bce8, 1'b0);
        apb(1'b1, `CRF_OFF_VECTOR_TABLE_BASE, 32'h0005_4321, 0, 1'b0);
        @(posedge pclk);
        check("vector base", 32'(view.vector_table_base), 32'h0005_4321);
        $display("test counter done");
        final_report();
    end
endmodule : tb
